//--- aacr_pkg.sv
package aacr_pkg;
   localparam logic [7:0] REG_PAGE        = 8'h00;
   localparam logic [7:0] REG_SRST        = 8'h01;
   localparam logic [7:0] REG_SLEEP       = 8'h02;
   localparam logic [7:0] REG_SHDN        = 8'h05;
   localparam logic [7:0] PAGE_RST        = 8'h00;
   localparam logic [7:0] SLEEP_RST       = 8'h00;
   localparam logic [7:0] SHDN_RST        = 8'h05;
   localparam logic [7:0] SLEEP_WMASK     = 8'hfd;
   localparam logic [7:0] SHDN_WMASK      = 8'h3f;
   localparam int         SRST_BIT        = 0;
   localparam int         SLP_WAKE_BIT    = 0;
   localparam int         SLP_BCAST_BIT   = 2;
   localparam int         SLP_VREF_LSB    = 3;
   localparam int         SLP_SUPPLY_BIT  = 7;
   localparam int         SHDN_INCAP_LSB  = 4;
   localparam logic [6:0] BCAST_ADDR      = 7'h4c;
   localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
   localparam int         CLK_MHZ         = 200;
   localparam int         TMR_W           = 25;
   // precharge times in microseconds, per two-bit code
   localparam int         VREF_T0_US      = 3500;
   localparam int         VREF_T1_US      = 10000;
   localparam int         VREF_T2_US      = 50000;
   localparam int         VREF_T3_US      = 100000;
   localparam int         INCAP_T0_US     = 2500;
   localparam int         INCAP_T1_US     = 12500;
   localparam int         INCAP_T2_US     = 25000;
   localparam int         INCAP_T3_US     = 50000;
   typedef enum logic [3:0] {
      AACR_IDLE, AACR_ADDR, AACR_ADDR_ACK, AACR_OFS, AACR_OFS_ACK,
      AACR_WR, AACR_WR_ACK, AACR_RD, AACR_RD_ACK
   } aacr_state_t;
endpackage : aacr_pkg

//--- aacr_config_regs.sv
`timescale 1ns/1ps
module aacr_config_regs #(
   parameter int unsigned VREF_CYC0  = aacr_pkg::VREF_T0_US * aacr_pkg::CLK_MHZ,
   parameter int unsigned VREF_CYC1  = aacr_pkg::VREF_T1_US * aacr_pkg::CLK_MHZ,
   parameter int unsigned VREF_CYC2  = aacr_pkg::VREF_T2_US * aacr_pkg::CLK_MHZ,
   parameter int unsigned VREF_CYC3  = aacr_pkg::VREF_T3_US * aacr_pkg::CLK_MHZ,
   parameter int unsigned INCAP_CYC0 = aacr_pkg::INCAP_T0_US * aacr_pkg::CLK_MHZ,
   parameter int unsigned INCAP_CYC1 = aacr_pkg::INCAP_T1_US * aacr_pkg::CLK_MHZ,
   parameter int unsigned INCAP_CYC2 = aacr_pkg::INCAP_T2_US * aacr_pkg::CLK_MHZ,
   parameter int unsigned INCAP_CYC3 = aacr_pkg::INCAP_T3_US * aacr_pkg::CLK_MHZ
) (
   input  wire logic       clock,                         // 200 MHz clock
   input  wire logic       resetn,                        // async reset, low
   input  wire logic [6:0] strap_addr,                    // strapped address
   input  wire logic       scl_in,                        // bus clock level
   input  wire logic       sda_in,                        // bus data level
   output logic            sda_out,                       // always low
   output logic            sda_oe,                        // pull data low
   output logic [7:0]      page_select,                   // current page
   output logic            analog_supply_source_sel,      // 1 = on-chip
   output logic [1:0]      reference_precharge_time,      // vref code
   output logic            broadcast_address_enable,      // fixed address on
   output logic [1:0]      input_coupling_precharge_time, // input cap code
   output logic            device_asleep,                 // sleep state
   output logic            reference_precharge_active,    // vref charging
   output logic            input_precharge_active         // input charging
);
   logic                   rst_s1_ff;
   logic                   rst_n;
   logic                   scl_ff;
   logic                   sda_ff;
   aacr_pkg::aacr_state_t  state_ff;
   logic [3:0]             cnt_ff;
   logic [7:0]             sh_ff;
   logic [7:0]             ptr_ff;
   logic                   rw_ff;
   logic                   nack_ff;
   logic                   sda_oe_ff;
   logic [7:0]             page_ff;
   logic                   srst_ff;
   logic [7:0]             sleep_ff;
   logic [7:0]             shdn_ff;
   logic                   wake_d_ff;
   logic                   scl_rise;
   logic                   scl_fall;
   logic                   bus_start;
   logic                   bus_stop;
   logic                   addr_hit;
   logic                   reg_wr;
   logic                   reg_sel_ok;
   logic [7:0]             rd_data;
   logic                   wake_start;
   logic [aacr_pkg::TMR_W-1:0] lim [2];
   wire  logic [1:0]       charge_act;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rst_s1_ff <= 1'b0;
         rst_n     <= 1'b0;
      end else begin
         rst_s1_ff <= 1'b1;
         rst_n     <= rst_s1_ff;
      end
   end

   assign scl_rise  = scl_in & ~scl_ff;
   assign scl_fall  = ~scl_in & scl_ff;
   assign bus_start = scl_in & scl_ff & sda_ff & ~sda_in;
   assign bus_stop  = scl_in & scl_ff & ~sda_ff & sda_in;
   // strapped address always works; fixed one only when enabled
   assign addr_hit  = (sh_ff[7:1] == strap_addr) |
                      (sleep_ff[aacr_pkg::SLP_BCAST_BIT] &
                       (sh_ff[7:1] == aacr_pkg::BCAST_ADDR));
   assign reg_wr    = (state_ff == aacr_pkg::AACR_WR) & scl_fall &
                      (cnt_ff == aacr_pkg::BITS_PER_BYTE);
   // offset zero is reachable from every page, the rest only on page 0
   assign reg_sel_ok = (ptr_ff == aacr_pkg::REG_PAGE) |
                       (page_ff == 8'h00);

   always_comb begin
      rd_data = 8'h00;
      if (reg_sel_ok) begin
         unique case (ptr_ff)
            aacr_pkg::REG_PAGE:  rd_data = page_ff;
            aacr_pkg::REG_SRST:  rd_data = {7'h00, srst_ff};
            aacr_pkg::REG_SLEEP: rd_data = sleep_ff;
            aacr_pkg::REG_SHDN:  rd_data = shdn_ff;
            default:             rd_data = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         scl_ff <= 1'b1;
         sda_ff <= 1'b1;
      end else begin
         scl_ff <= scl_in;
         sda_ff <= sda_in;
      end
   end

   // control bus slave; the register soft reset leaves it running
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= aacr_pkg::AACR_IDLE;
         cnt_ff   <= 4'h0;
         sh_ff    <= 8'h00;
         ptr_ff   <= 8'h00;
         rw_ff    <= 1'b0;
         nack_ff  <= 1'b0;
      end else if (bus_start) begin
         state_ff <= aacr_pkg::AACR_ADDR;
         cnt_ff   <= 4'h0;
      end else if (bus_stop) begin
         state_ff <= aacr_pkg::AACR_IDLE;
      end else begin
         unique case (state_ff)
            aacr_pkg::AACR_IDLE: ;
            aacr_pkg::AACR_ADDR, aacr_pkg::AACR_OFS, aacr_pkg::AACR_WR: begin
               if (scl_rise && cnt_ff < aacr_pkg::BITS_PER_BYTE) begin
                  sh_ff  <= {sh_ff[6:0], sda_in};
                  cnt_ff <= cnt_ff + 4'h1;
               end else if (scl_fall &&
                            cnt_ff == aacr_pkg::BITS_PER_BYTE) begin
                  cnt_ff <= 4'h0;
                  if (state_ff == aacr_pkg::AACR_ADDR) begin
                     rw_ff    <= sh_ff[0];
                     state_ff <= addr_hit ? aacr_pkg::AACR_ADDR_ACK
                                          : aacr_pkg::AACR_IDLE;
                  end else if (state_ff == aacr_pkg::AACR_OFS) begin
                     ptr_ff   <= sh_ff;
                     state_ff <= aacr_pkg::AACR_OFS_ACK;
                  end else begin
                     ptr_ff   <= ptr_ff + 8'h01;
                     state_ff <= aacr_pkg::AACR_WR_ACK;
                  end
               end
            end
            aacr_pkg::AACR_ADDR_ACK: begin
               if (scl_fall) begin
                  cnt_ff <= 4'h0;
                  if (rw_ff) begin
                     sh_ff    <= rd_data;
                     ptr_ff   <= ptr_ff + 8'h01;
                     state_ff <= aacr_pkg::AACR_RD;
                  end else begin
                     state_ff <= aacr_pkg::AACR_OFS;
                  end
               end
            end
            aacr_pkg::AACR_OFS_ACK, aacr_pkg::AACR_WR_ACK: begin
               if (scl_fall) begin
                  state_ff <= aacr_pkg::AACR_WR;
               end
            end
            aacr_pkg::AACR_RD: begin
               if (scl_fall) begin
                  sh_ff  <= {sh_ff[6:0], 1'b0};
                  cnt_ff <= cnt_ff + 4'h1;
                  if (cnt_ff == 4'h7) begin
                     state_ff <= aacr_pkg::AACR_RD_ACK;
                  end
               end
            end
            aacr_pkg::AACR_RD_ACK: begin
               if (scl_rise) begin
                  nack_ff <= sda_in;
               end else if (scl_fall) begin
                  cnt_ff <= 4'h0;
                  if (nack_ff) begin
                     state_ff <= aacr_pkg::AACR_IDLE;
                  end else begin
                     sh_ff    <= rd_data;
                     ptr_ff   <= ptr_ff + 8'h01;
                     state_ff <= aacr_pkg::AACR_RD;
                  end
               end
            end
         endcase
      end
   end

   // one cycle behind the state is far inside the bus data hold time
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sda_oe_ff <= 1'b0;
      end else begin
         sda_oe_ff <= (state_ff == aacr_pkg::AACR_ADDR_ACK) |
                      (state_ff == aacr_pkg::AACR_OFS_ACK) |
                      (state_ff == aacr_pkg::AACR_WR_ACK) |
                      ((state_ff == aacr_pkg::AACR_RD) & ~sh_ff[7]);
      end
   end
   assign sda_out = 1'b0;
   assign sda_oe  = sda_oe_ff;

   // register file; the request bit lives one cycle, then resets all
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         page_ff  <= aacr_pkg::PAGE_RST;
         srst_ff  <= 1'b0;
         sleep_ff <= aacr_pkg::SLEEP_RST;
         shdn_ff  <= aacr_pkg::SHDN_RST;
      end else if (srst_ff) begin
         page_ff  <= aacr_pkg::PAGE_RST;
         srst_ff  <= 1'b0;
         sleep_ff <= aacr_pkg::SLEEP_RST;
         shdn_ff  <= aacr_pkg::SHDN_RST;
      end else if (reg_wr && reg_sel_ok) begin
         unique case (ptr_ff)
            aacr_pkg::REG_PAGE:  page_ff  <= sh_ff;
            aacr_pkg::REG_SRST:  srst_ff  <= sh_ff[aacr_pkg::SRST_BIT];
            aacr_pkg::REG_SLEEP: sleep_ff <= sh_ff & aacr_pkg::SLEEP_WMASK;
            aacr_pkg::REG_SHDN:  shdn_ff  <= sh_ff & aacr_pkg::SHDN_WMASK;
            default: ;
         endcase
      end
   end

   assign page_select                   = page_ff;
   assign analog_supply_source_sel      =
      sleep_ff[aacr_pkg::SLP_SUPPLY_BIT];
   assign reference_precharge_time      =
      sleep_ff[aacr_pkg::SLP_VREF_LSB +: 2];
   assign broadcast_address_enable      = sleep_ff[aacr_pkg::SLP_BCAST_BIT];
   assign input_coupling_precharge_time = shdn_ff[aacr_pkg::SHDN_INCAP_LSB +: 2];
   assign device_asleep = ~sleep_ff[aacr_pkg::SLP_WAKE_BIT];

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wake_d_ff <= 1'b0;
      end else begin
         wake_d_ff <= sleep_ff[aacr_pkg::SLP_WAKE_BIT];
      end
   end
   assign wake_start = sleep_ff[aacr_pkg::SLP_WAKE_BIT] & ~wake_d_ff;

   always_comb begin
      unique case (reference_precharge_time)
         2'd0: lim[0] = aacr_pkg::TMR_W'(VREF_CYC0);
         2'd1: lim[0] = aacr_pkg::TMR_W'(VREF_CYC1);
         2'd2: lim[0] = aacr_pkg::TMR_W'(VREF_CYC2);
         2'd3: lim[0] = aacr_pkg::TMR_W'(VREF_CYC3);
      endcase
      unique case (input_coupling_precharge_time)
         2'd0: lim[1] = aacr_pkg::TMR_W'(INCAP_CYC0);
         2'd1: lim[1] = aacr_pkg::TMR_W'(INCAP_CYC1);
         2'd2: lim[1] = aacr_pkg::TMR_W'(INCAP_CYC2);
         2'd3: lim[1] = aacr_pkg::TMR_W'(INCAP_CYC3);
      endcase
   end

   // code is latched at wake; a later change does not stretch a charge
   for (genvar gi = 0; gi < 2; gi++) begin : g_tmr
      logic [aacr_pkg::TMR_W-1:0] tmr_ff;
      logic                       act_ff;
      always_ff @(posedge clock or negedge rst_n) begin
         if (!rst_n) begin
            tmr_ff <= '0;
            act_ff <= 1'b0;
         end else if (!sleep_ff[aacr_pkg::SLP_WAKE_BIT]) begin
            tmr_ff <= '0;
            act_ff <= 1'b0;
         end else if (wake_start) begin
            tmr_ff <= lim[gi] - aacr_pkg::TMR_W'(1);
            act_ff <= 1'b1;
         end else if (act_ff) begin
            tmr_ff <= tmr_ff - aacr_pkg::TMR_W'(1);
            act_ff <= (tmr_ff != '0);
         end
      end
      assign charge_act[gi] = act_ff;
   end
   assign reference_precharge_active = charge_act[0];
   assign input_precharge_active     = charge_act[1];

   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence wake_seq;
      wake_start;
   endsequence
   sequence addr_done_seq;
      state_ff == aacr_pkg::AACR_ADDR && scl_fall &&
      cnt_ff == aacr_pkg::BITS_PER_BYTE;
   endsequence

   page_write_a: assert property (reg_wr && ptr_ff == aacr_pkg::REG_PAGE &&
      !srst_ff |=> page_select == $past(sh_ff))
      else $error("page write not taken");
   soft_reset_a: assert property (srst_ff |=> page_ff == aacr_pkg::PAGE_RST
      && sleep_ff == aacr_pkg::SLEEP_RST && shdn_ff == aacr_pkg::SHDN_RST)
      else $error("soft reset left a field");
   self_clear_a: assert property (srst_ff |=> !srst_ff ##1 !srst_ff [*2]
      or $past(reg_wr))
      else $error("reset request stuck");
   sleep_default_a: assert property (srst_ff |=> device_asleep &&
      !reference_precharge_active)
      else $error("not asleep after reset");
   supply_sel_a: assert property (reg_wr && reg_sel_ok && !srst_ff &&
      ptr_ff == aacr_pkg::REG_SLEEP |=> analog_supply_source_sel ==
      $past(sh_ff[7]))
      else $error("supply select not updated");
   vref_time_a: assert property (wake_seq |=>
      g_tmr[0].tmr_ff == $past(lim[0]) - aacr_pkg::TMR_W'(1))
      else $error("reference charge length wrong");
   bcast_addr_a: assert property (addr_done_seq and ##0
      (broadcast_address_enable && sh_ff[7:1] == aacr_pkg::BCAST_ADDR)
      |=> state_ff == aacr_pkg::AACR_ADDR_ACK ##1 sda_oe)
      else $error("broadcast address not acknowledged");
   incap_time_a: assert property (wake_seq |=>
      g_tmr[1].tmr_ff == $past(lim[1]) - aacr_pkg::TMR_W'(1))
      else $error("input charge length wrong");
   charge_end_a: assert property (input_precharge_active &&
      g_tmr[1].tmr_ff == '0 && !wake_start |=> !input_precharge_active)
      else $error("charge did not end");
endmodule : aacr_config_regs

//--- aacr_host_model.sv
`timescale 1ns/1ps
module aacr_host_model (
   input  wire logic clock,    // system clock
   input  wire logic sda_in,   // resolved data wire
   output logic      scl,      // bus clock
   output logic      sda_pull  // high = host pulls data low
);
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : tick
   // 4-clock phases keep clear of the 3-clock minimum
   task automatic put_bit(input logic b);
      sda_pull = ~b;
      tick(4);
      scl = 1'b1;
      tick(4);
      scl = 1'b0;
   endtask : put_bit
   task automatic get_bit(output logic b);
      sda_pull = 1'b0;
      tick(4);
      scl = 1'b1;
      tick(2);
      b = sda_in;
      tick(2);
      scl = 1'b0;
   endtask : get_bit
   task automatic start_cond;
      sda_pull = 1'b0;
      tick(4);
      scl = 1'b1;
      tick(4);
      sda_pull = 1'b1;
      tick(4);
      scl = 1'b0;
   endtask : start_cond
   task automatic stop_cond;
      sda_pull = 1'b1;
      tick(4);
      scl = 1'b1;
      tick(4);
      sda_pull = 1'b0;
      tick(4);
   endtask : stop_cond
   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) put_bit(d[i]);
      get_bit(b);
      ack = ~b;
   endtask : put_byte
   task automatic get_byte(output logic [7:0] d);
      for (int i = 7; i >= 0; i--) get_bit(d[i]);
      put_bit(1'b1); // single-byte reads end with a nack
   endtask : get_byte
   task automatic write_reg(input logic [6:0] a, input logic [7:0] ofs,
                            input logic [7:0] d, output logic ack);
      logic a0, a1, a2;
      start_cond;
      put_byte({a, 1'b0}, a0);
      put_byte(ofs, a1);
      put_byte(d, a2);
      stop_cond;
      ack = a0 & a1 & a2;
   endtask : write_reg
   task automatic read_reg(input logic [6:0] a, input logic [7:0] ofs,
                           output logic [7:0] d, output logic ack);
      logic a0, a1, a2;
      start_cond;
      put_byte({a, 1'b0}, a0);
      put_byte(ofs, a1);
      start_cond;
      put_byte({a, 1'b1}, a2);
      get_byte(d);
      stop_cond;
      ack = a0 & a1 & a2;
   endtask : read_reg
   task automatic set_page(input logic [6:0] a, input logic [7:0] p,
                           output logic ack);
      write_reg(a, aacr_pkg::REG_PAGE, p, ack);
   endtask : set_page
endmodule : aacr_host_model

//--- tb_audio_adc_device_config_regs.sv
`timescale 1ns/1ps
module tb_audio_adc_device_config_regs;
   localparam logic [6:0] STRAP = 7'h18;
   typedef struct {logic [7:0] ofs; logic [7:0] wr; logic [7:0] rd;} aacr_row_t;
   logic clock, resetn, scl, host_pull, sda_in, sda_out, sda_oe, ack;
   logic [7:0] page_select, rd;
   logic [1:0] vref_code, incap_code;
   logic       supply_sel, bcast_en, device_asleep, vref_act, incap_act;
   int         mismatches, checks, cycles, vref_cnt, incap_cnt;
   aacr_row_t  rows [5] = '{'{8'h02, 8'h9d, 8'h9d}, '{8'h02, 8'h00, 8'h00},
      '{8'h05, 8'h35, 8'h35}, '{8'h05, 8'h05, 8'h05}, '{8'h03, 8'haa, 8'h00}};
   assign sda_in = ~(host_pull | sda_oe); // pull-up on the data wire
   aacr_host_model aacr_host_model_inst (.clock(clock), .sda_in(sda_in),
      .scl(scl), .sda_pull(host_pull));
   // only the two codes timed below are shortened; the others keep their
   // full length and are always put back to sleep long before they end
   aacr_config_regs #(.VREF_CYC1(40), .INCAP_CYC2(70))
      aacr_config_regs_inst (.clock(clock),
      .resetn(resetn), .strap_addr(STRAP), .scl_in(scl), .sda_in(sda_in),
      .sda_out(sda_out), .sda_oe(sda_oe), .page_select(page_select),
      .analog_supply_source_sel(supply_sel),
      .reference_precharge_time(vref_code),
      .broadcast_address_enable(bcast_en),
      .input_coupling_precharge_time(incap_code),
      .device_asleep(device_asleep),
      .reference_precharge_active(vref_act),
      .input_precharge_active(incap_act));
   always #2.5 clock = ~clock;
   always @(posedge clock) begin
      cycles++;
      if (vref_act === 1'b1) vref_cnt++;
      if (incap_act === 1'b1) incap_cnt++;
      if (cycles == 30000) begin
         mismatches++;
         test_done;
      end
   end
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk8
   task automatic chk1(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk1
   task automatic wr(input logic [6:0] a, input logic [7:0] o, d, x);
      aacr_host_model_inst.write_reg(a, o, d, ack);
      chk1(ack, x[0]);
   endtask : wr
   task automatic rd_chk(input logic [6:0] a, input logic [7:0] o, e);
      aacr_host_model_inst.read_reg(a, o, rd, ack);
      chk1(ack, 1'b1);
      chk8(rd, e);
   endtask : rd_chk
   task automatic test_done;
      $display("mismatches=%0d checks=%0d", mismatches, checks);
      if (mismatches == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : test_done
   initial begin
      clock = 1'b0;
      resetn = 1'b0;
      repeat (3) @(posedge clock);
      #1 resetn = 1'b1;
      aacr_host_model_inst.tick(4);
      chk1(device_asleep, 1'b1);
      chk8(page_select, 8'h00);
      chk1(sda_out, 1'b0); // open drain data wire
      rd_chk(STRAP, 8'h01, 8'h00);
      rd_chk(STRAP, 8'h02, 8'h00);
      rd_chk(STRAP, 8'h05, 8'h05);
      // reserved fields of 02 and 05 are written only with their reset patterns; unused offset 03 is written aa and reads 00
      foreach (rows[i]) begin
         wr(STRAP, rows[i].ofs, rows[i].wr, 1'b1);
         rd_chk(STRAP, rows[i].ofs, rows[i].rd);
      end
      // broadcast address answered only while enabled
      wr(STRAP, 8'h02, 8'h9c, 1'b1);
      chk1(supply_sel, 1'b1);
      chk8({6'h00, vref_code}, 8'h03);
      chk1(bcast_en, 1'b1);
      rd_chk(aacr_pkg::BCAST_ADDR, 8'h02, 8'h9c);
      wr(aacr_pkg::BCAST_ADDR, 8'h02, 8'h00, 1'b1);
      wr(aacr_pkg::BCAST_ADDR, 8'h02, 8'h00, 1'b0);
      wr(7'h19, 8'h02, 8'h01, 1'b0);
      chk1(device_asleep, 1'b1);
      // on another page only offset zero is reachable
      aacr_host_model_inst.set_page(STRAP, 8'hff, ack);
      chk1(ack, 1'b1);
      chk8(page_select, 8'hff);
      wr(STRAP, 8'h02, 8'h80, 1'b1);
      rd_chk(STRAP, 8'h02, 8'h00);
      rd_chk(STRAP, 8'h00, 8'hff);
      aacr_host_model_inst.set_page(STRAP, 8'h00, ack);
      rd_chk(STRAP, 8'h02, 8'h00);
      // wake with vref code 1 and input code 2, then time both charges
      wr(STRAP, 8'h05, 8'h25, 1'b1);
      chk8({6'h00, incap_code}, 8'h02);
      vref_cnt = 0;
      incap_cnt = 0;
      wr(STRAP, 8'h02, 8'h09, 1'b1);
      chk1(device_asleep, 1'b0);
      aacr_host_model_inst.tick(150);
      chk1(vref_cnt == 40 || vref_cnt == 41, 1'b1);
      chk1(incap_cnt == 70 || incap_cnt == 71, 1'b1);
      // soft reset puts everything back and clears its own request
      wr(STRAP, 8'h01, 8'h01, 1'b1);
      rd_chk(STRAP, 8'h01, 8'h00);
      rd_chk(STRAP, 8'h02, 8'h00);
      rd_chk(STRAP, 8'h05, 8'h05);
      chk1(device_asleep, 1'b1);
      test_done;
   end
endmodule : tb_audio_adc_device_config_regs
